/* src/rsd_pkg.sv */
// Constants, types and register map of the reference select and loop control block
package rsd_pkg;

    localparam int NUM_REF = 5;
    localparam int REF_IW  = 3;

    // Clock and timing
    localparam int CLK_HZ            = 25_000_000;
    localparam int CLK_MHZ           = 25;
    localparam int ACT_TIMEOUT_US    = 1000;
    localparam int ACT_TIMEOUT_CYC   = ACT_TIMEOUT_US * CLK_MHZ;
    localparam int LOCK_TIME_US      = 100;
    localparam int LOCK_CYC          = LOCK_TIME_US * CLK_MHZ;
    localparam int FS_HZ             = 8000;
    localparam int MF_HZ             = 2000;
    localparam int FS_PERIOD_CYC     = CLK_HZ / FS_HZ;
    localparam int MF_PERIOD_CYC     = CLK_HZ / MF_HZ;

    // Register offsets
    localparam logic [5:0] RA_CTL_ONE   = 6'h00;
    localparam logic [5:0] RA_CTL_TEN   = 6'h01;
    localparam logic [5:0] RA_FORCE_P   = 6'h02;
    localparam logic [5:0] RA_FORCE_M   = 6'h03;
    localparam logic [5:0] RA_BW        = 6'h04;
    localparam logic [5:0] RA_PHASE_CTL = 6'h05;
    localparam logic [5:0] RA_PRI_P     = 6'h08;
    localparam logic [5:0] RA_PRI_M     = 6'h10;
    localparam logic [5:0] RA_STAT_TWO  = 6'h20;
    localparam logic [5:0] RA_ACTIVITY  = 6'h21;
    localparam logic [5:0] RA_SEL       = 6'h22;
    localparam logic [5:0] RA_MSTATE    = 6'h23;
    localparam logic [5:0] RA_PHASE_LO  = 6'h24;
    localparam logic [5:0] RA_PHASE_HI  = 6'h25;

    // Field positions
    localparam int B1_LOCK_PIN_EN = 0;
    localparam int B1_MAN_STATE   = 1;
    localparam int B1_STATE_LSB   = 2;
    localparam int BT_FAIL_PIN_EN = 0;
    localparam int BT_BYPASS_EN   = 1;
    localparam int BT_BYPASS_DIFF = 2;
    localparam int BT_ALIGN_EN    = 3;
    localparam int BT_SYNC_LSB    = 4;
    localparam int BF_FORCE_EN    = 3;
    localparam int BP_PHASE_EN    = 0;
    localparam int BP_A_LSB       = 1;
    localparam int BP_B_LSB       = 4;
    localparam logic [2:0] BW_MAX_CODE = 3'h5;

    // Reset values
    localparam logic [7:0] CTL_ONE_RST = 8'h00;
    localparam logic [7:0] CTL_TEN_RST = 8'h00;
    localparam logic [NUM_REF-1:0][3:0] PRI_RST = {4'h5, 4'h4, 4'h3, 4'h2, 4'h1};

    typedef enum logic [1:0] {
        PS_FREE   = 2'b00,
        PS_LOCKED = 2'b01,
        PS_HOLD   = 2'b10
    } rsd_pstate_e;

    typedef enum logic {
        MS_UNLOCKED = 1'b0,
        MS_LOCKED   = 1'b1
    } rsd_mstate_e;

    typedef struct packed {
        logic                      found;
        logic [REF_IW-1:0]         idx;
    } rsd_pick_s;

    typedef struct packed {
        logic [NUM_REF-1:0]        ref_s1;
        logic [NUM_REF-1:0]        ref_s2;
        logic [NUM_REF-1:0]        ref_d;
        logic [2:0]                sync_s1;
        logic [2:0]                sync_s2;
        logic [2:0]                sync_d;
        logic [NUM_REF-1:0][15:0]  idle_cnt;
        logic [NUM_REF-1:0]        active;
        logic [NUM_REF-1:0][3:0]   pri_p;
        logic [NUM_REF-1:0][3:0]   pri_m;
        logic [7:0]                ctl_one;
        logic [7:0]                ctl_ten;
        logic [7:0]                force_p;
        logic [7:0]                force_m;
        logic [7:0]                bw;
        logic [7:0]                phase_ctl;
        rsd_pstate_e               pstate;
        rsd_mstate_e               mstate;
        logic [11:0]               lock_cnt;
        logic [REF_IW-1:0]         sel_p;
        logic [REF_IW-1:0]         sel_m;
        logic                      fail;
        logic                      ph_run;
        logic [15:0]               ph_cnt;
        logic [15:0]               ph_val;
        logic [11:0]               fs_cnt;
        logic [13:0]               mf_cnt;
        logic                      fs_o;
        logic                      mf_o;
        logic                      se_o;
        logic                      df_o;
        logic                      lock_o;
        logic [7:0]                rdata;
    } rsd_state_s;

    localparam rsd_state_s RSD_RST = '{
        pri_p:   PRI_RST,
        pri_m:   PRI_RST,
        ctl_one: CTL_ONE_RST,
        ctl_ten: CTL_TEN_RST,
        pstate:  PS_FREE,
        mstate:  MS_UNLOCKED,
        default: '0
    };

endpackage

/* src/rsd_ref_select.sv */
// Reference selection, loop state control and frame sync generation
`timescale 1ns/1ps

// Notes on behaviour
// - Every reference input is watched for edges; silent inputs become inactive.
// - Each input has priority number; zero marks it unavailable.
// - Primary loop and monitor loop keep separate priority tables.
// - Primary loop picks highest-priority valid input automatically.
// - Failure flag follows activity of the currently selected primary input.
// - Software force selection overrides automatic choice in either loop.
// - Primary loop moves between free-run, locked and holdover automatically.
// - Software may take manual control of the primary loop state.
// - Monitor loop has simple state machine software cannot command.
// - Monitor loop never drives output clocks through the loop.
// - Optional phase measurement between two chosen inputs.
// - Bypass routes monitor selected reference to single-ended or differential output.
// - Frame sync output aligns to 2/4/8 kHz sync from one of three pins; multiframe sync is not aligned.
// - Frame sync output fixed at 8 kHz, multiframe sync at 2 kHz.
// - Each loop offers six bandwidth codes from 18 Hz to 400 Hz.
// - Fail pin follows failure flag when enabled, else high impedance.
// - Lock pin shows primary lock when enabled, else driven low.
module rsd_ref_select
    import rsd_pkg::*;
#(
    parameter logic [15:0] ACT_TIMEOUT = 16'(ACT_TIMEOUT_CYC),
    parameter logic [13:0] MF_PERIOD   = 14'(MF_PERIOD_CYC)
)(
    input  wire logic               mclk,
    input  wire logic               reset_n,
    input  wire logic [5:0]         reg_addr,
    input  wire logic [7:0]         reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output logic      [7:0]         reg_rdata,
    input  wire logic [NUM_REF-1:0] ref_clk_in,
    input  wire logic               sync_input_one,
    input  wire logic               sync_input_two,
    input  wire logic               sync_input_three,
    output logic                    single_ended_out_clock,
    output logic                    differential_out_clock,
    output logic                    frame_sync_out,
    output logic                    multiframe_sync_out,
    output logic                    selected_ref_fail_o,
    output logic                    selected_ref_fail_oe,
    output logic                    lock_status,
    output logic      [2:0]         primary_bw,
    output logic      [2:0]         monitor_bw
);

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic rsd_pick_s pick_best(input logic [NUM_REF-1:0][3:0] pri,
                                            input logic [NUM_REF-1:0]      ok);
        rsd_pick_s  r;
        logic [3:0] bp;
        r  = '0;
        bp = 4'h0;
        for (int i = 0; i < NUM_REF; i++)
        begin
            if (ok[i] && pri[i] != 4'h0 && (!r.found || pri[i] < bp))
            begin
                r.found = 1'b1;
                bp      = pri[i];
                r.idx   = REF_IW'(i);
            end
        end
        return r;
    endfunction

    function automatic logic [REF_IW-1:0] choose(input logic [7:0]        force_reg,
                                                 input rsd_pick_s         best,
                                                 input logic [REF_IW-1:0] cur);
        if (force_reg[BF_FORCE_EN] && force_reg[REF_IW-1:0] < REF_IW'(NUM_REF))
            return force_reg[REF_IW-1:0];
        else if (best.found)
            return best.idx;
        else
            return cur;
    endfunction

    function automatic logic [2:0] clamp_bw(input logic [2:0] code);
        return (code > BW_MAX_CODE) ? BW_MAX_CODE : code;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Reset release

    logic rst_s1_ff;
    logic rst_n_ff;

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rst_s1_ff <= 1'b0;
            rst_n_ff  <= 1'b0;
        end
        else
        begin
            rst_s1_ff <= 1'b1;
            rst_n_ff  <= rst_s1_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State

    rsd_state_s s_ff;
    rsd_state_s nxt_s;
    rsd_pick_s  best_p;
    rsd_pick_s  best_m;
    logic [2:0] sync_edge;
    logic       sync_hit;
    logic [NUM_REF-1:0] ref_edge;
    logic [REF_IW-1:0] ph_a;
    logic [REF_IW-1:0] ph_b;
    logic [7:0] rd;
    logic [2:0] widx;

    always_comb
    begin
        nxt_s = s_ff;
        rd    = 8'h00;
        widx  = 3'h0;

        nxt_s.ref_s1  = ref_clk_in;
        nxt_s.ref_s2  = s_ff.ref_s1;
        nxt_s.ref_d   = s_ff.ref_s2;
        nxt_s.sync_s1 = {sync_input_three, sync_input_two, sync_input_one};
        nxt_s.sync_s2 = s_ff.sync_s1;
        nxt_s.sync_d  = s_ff.sync_s2;
        ref_edge  = s_ff.ref_s2 & ~s_ff.ref_d;
        sync_edge = s_ff.sync_s2 & ~s_ff.sync_d;

        // Activity watch
        for (int i = 0; i < NUM_REF; i++)
        begin
            if (ref_edge[i])
            begin
                nxt_s.idle_cnt[i] = 16'h0000;
                nxt_s.active[i]   = 1'b1;
            end
            else if (s_ff.idle_cnt[i] >= ACT_TIMEOUT - 16'h0001)
                nxt_s.active[i] = 1'b0;
            else
                nxt_s.idle_cnt[i] = s_ff.idle_cnt[i] + 16'h0001;
        end

        // Selection per loop, each from its own table
        best_p      = pick_best(s_ff.pri_p, s_ff.active);
        best_m      = pick_best(s_ff.pri_m, s_ff.active);
        nxt_s.sel_p = choose(s_ff.force_p, best_p, s_ff.sel_p);
        nxt_s.sel_m = choose(s_ff.force_m, best_m, s_ff.sel_m);
        nxt_s.fail  = !s_ff.active[s_ff.sel_p];

        // Primary loop state machine
        if (s_ff.ctl_one[B1_MAN_STATE])
        begin
            nxt_s.lock_cnt = 12'h000;
            case (s_ff.ctl_one[B1_STATE_LSB +: 2])
                2'b01:   nxt_s.pstate = PS_LOCKED;
                2'b10:   nxt_s.pstate = PS_HOLD;
                default: nxt_s.pstate = PS_FREE;
            endcase
        end
        else
        begin
            case (s_ff.pstate)
                PS_FREE, PS_HOLD:
                begin
                    if (!s_ff.active[s_ff.sel_p])
                        nxt_s.lock_cnt = 12'h000;
                    else if (s_ff.lock_cnt >= 12'(LOCK_CYC - 1))
                    begin
                        nxt_s.pstate   = PS_LOCKED;
                        nxt_s.lock_cnt = 12'h000;
                    end
                    else
                        nxt_s.lock_cnt = s_ff.lock_cnt + 12'h001;
                end
                PS_LOCKED:
                begin
                    if (!s_ff.active[s_ff.sel_p] && !best_p.found)
                        nxt_s.pstate = PS_HOLD;
                end
                default: nxt_s.pstate = PS_FREE;
            endcase
        end

        // Monitor loop, status only
        case (s_ff.mstate)
            MS_UNLOCKED: if (s_ff.active[s_ff.sel_m]) nxt_s.mstate = MS_LOCKED;
            MS_LOCKED:   if (!s_ff.active[s_ff.sel_m]) nxt_s.mstate = MS_UNLOCKED;
            default:     nxt_s.mstate = MS_UNLOCKED;
        endcase

        // Phase measurement between two inputs
        ph_a = s_ff.phase_ctl[BP_A_LSB +: REF_IW];
        ph_b = s_ff.phase_ctl[BP_B_LSB +: REF_IW];
        if (!s_ff.phase_ctl[BP_PHASE_EN] || ph_a >= REF_IW'(NUM_REF)
            || ph_b >= REF_IW'(NUM_REF))
            nxt_s.ph_run = 1'b0;
        else if (s_ff.ph_run && ref_edge[ph_b])
        begin
            nxt_s.ph_run = 1'b0;
            nxt_s.ph_val = s_ff.ph_cnt;
        end
        else if (ref_edge[ph_a])
        begin
            nxt_s.ph_run = 1'b1;
            nxt_s.ph_cnt = 16'h0001; // Span includes the start cycle
        end
        else if (s_ff.ph_run && s_ff.ph_cnt != 16'hFFFF)
            nxt_s.ph_cnt = s_ff.ph_cnt + 16'h0001;

        // Frame and multiframe sync
        sync_hit = s_ff.ctl_ten[BT_ALIGN_EN]
                   && s_ff.ctl_ten[BT_SYNC_LSB +: 2] != 2'b11
                   && sync_edge[s_ff.ctl_ten[BT_SYNC_LSB +: 2]];
        if (sync_hit || s_ff.fs_cnt >= 12'(FS_PERIOD_CYC - 1))
            nxt_s.fs_cnt = 12'h000;
        else
            nxt_s.fs_cnt = s_ff.fs_cnt + 12'h001;
        if (s_ff.mf_cnt >= MF_PERIOD - 14'h0001)
            nxt_s.mf_cnt = 14'h0000;
        else
            nxt_s.mf_cnt = s_ff.mf_cnt + 14'h0001;
        nxt_s.fs_o = s_ff.fs_cnt < 12'(FS_PERIOD_CYC / 2);
        nxt_s.mf_o = s_ff.mf_cnt < (MF_PERIOD >> 1);

        // Output clocks: primary reference unless bypassed
        nxt_s.se_o = s_ff.ref_s2[s_ff.sel_p];
        nxt_s.df_o = s_ff.ref_s2[s_ff.sel_p];
        if (s_ff.ctl_ten[BT_BYPASS_EN])
        begin
            if (s_ff.ctl_ten[BT_BYPASS_DIFF])
                nxt_s.df_o = s_ff.ref_s2[s_ff.sel_m];
            else
                nxt_s.se_o = s_ff.ref_s2[s_ff.sel_m];
        end

        nxt_s.lock_o = s_ff.ctl_one[B1_LOCK_PIN_EN]
                       && s_ff.pstate == PS_LOCKED;

        // Register writes
        if (reg_wr)
        begin
            widx = 3'(reg_addr[2:0]);
            if (reg_addr == RA_CTL_ONE)
                nxt_s.ctl_one = reg_wdata;
            else if (reg_addr == RA_CTL_TEN)
                nxt_s.ctl_ten = reg_wdata;
            else if (reg_addr == RA_FORCE_P)
                nxt_s.force_p = reg_wdata;
            else if (reg_addr == RA_FORCE_M)
                nxt_s.force_m = reg_wdata;
            else if (reg_addr == RA_BW)
                nxt_s.bw = {1'b0, clamp_bw(reg_wdata[6:4]), 1'b0, clamp_bw(reg_wdata[2:0])};
            else if (reg_addr == RA_PHASE_CTL)
                nxt_s.phase_ctl = reg_wdata;
            else if (reg_addr[5:3] == RA_PRI_P[5:3] && widx < 3'(NUM_REF))
                nxt_s.pri_p[widx] = reg_wdata[3:0];
            else if (reg_addr[5:3] == RA_PRI_M[5:3] && widx < 3'(NUM_REF))
                nxt_s.pri_m[widx] = reg_wdata[3:0];
        end

        // Register reads, data one cycle later
        if (reg_addr == RA_CTL_ONE)
            rd = s_ff.ctl_one;
        else if (reg_addr == RA_CTL_TEN)
            rd = s_ff.ctl_ten;
        else if (reg_addr == RA_FORCE_P)
            rd = s_ff.force_p;
        else if (reg_addr == RA_FORCE_M)
            rd = s_ff.force_m;
        else if (reg_addr == RA_BW)
            rd = s_ff.bw;
        else if (reg_addr == RA_PHASE_CTL)
            rd = s_ff.phase_ctl;
        else if (reg_addr[5:3] == RA_PRI_P[5:3] && reg_addr[2:0] < 3'(NUM_REF))
            rd = {4'h0, s_ff.pri_p[reg_addr[2:0]]};
        else if (reg_addr[5:3] == RA_PRI_M[5:3] && reg_addr[2:0] < 3'(NUM_REF))
            rd = {4'h0, s_ff.pri_m[reg_addr[2:0]]};
        else if (reg_addr == RA_STAT_TWO)
            rd = {4'h0, s_ff.pstate, s_ff.pstate == PS_LOCKED, s_ff.fail};
        else if (reg_addr == RA_ACTIVITY)
            rd = {3'h0, s_ff.active};
        else if (reg_addr == RA_SEL)
            rd = {1'b0, s_ff.sel_m, 1'b0, s_ff.sel_p};
        else if (reg_addr == RA_MSTATE)
            rd = {7'h00, s_ff.mstate};
        else if (reg_addr == RA_PHASE_LO)
            rd = s_ff.ph_val[7:0];
        else if (reg_addr == RA_PHASE_HI)
            rd = s_ff.ph_val[15:8];
        nxt_s.rdata = reg_rd ? rd : 8'h00;
    end

    always_ff @(posedge mclk or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
            s_ff <= RSD_RST;
        else
            s_ff <= nxt_s;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign reg_rdata              = s_ff.rdata;
    assign single_ended_out_clock = s_ff.se_o;
    assign differential_out_clock = s_ff.df_o;
    assign frame_sync_out         = s_ff.fs_o;
    assign multiframe_sync_out    = s_ff.mf_o;
    assign selected_ref_fail_o    = s_ff.fail;
    assign selected_ref_fail_oe   = s_ff.ctl_ten[BT_FAIL_PIN_EN];
    assign lock_status            = s_ff.lock_o;
    assign primary_bw             = s_ff.bw[2:0];
    assign monitor_bw             = s_ff.bw[6:4];

endmodule

/* sim/rsd_ref_select_properties.sv */
// Port-level checks for the reference select block
`timescale 1ns/1ps
module rsd_ref_select_checker
    import rsd_pkg::*;
#(
    parameter logic [15:0] ACT_TIMEOUT = 16'h0032,
    parameter logic [13:0] MF_PERIOD   = 14'h0028
)(
    input wire logic               mclk,
    input wire logic               reset_n,
    input wire logic [5:0]         reg_addr,
    input wire logic               reg_wr,
    input wire logic               reg_rd,
    input wire logic [7:0]         reg_rdata,
    input wire logic [NUM_REF-1:0] ref_clk_in,
    input wire logic [2:0]         sync_pins,
    input wire logic               frame_sync_out,
    input wire logic               multiframe_sync_out,
    input wire logic               selected_ref_fail_oe,
    input wire logic               lock_status,
    input wire logic [2:0]         primary_bw,
    input wire logic [2:0]         monitor_bw
);
    localparam int IDLE_LIM = int'(ACT_TIMEOUT) + 12;
    logic [NUM_REF-1:0] ref_q_ff;
    logic               fs_q_ff;
    logic               mf_q_ff;
    logic               warm_ff;
    logic [13:0]        fs_len_ff;
    logic [13:0]        mf_len_ff;
    logic [15:0]        idle_ff;
    wire logic          ten_wr = reg_wr && (reg_addr == RA_CTL_TEN);

    // Level lengths and time since any reference edge
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ref_q_ff  <= '0;
            fs_q_ff   <= 1'b0;
            mf_q_ff   <= 1'b0;
            warm_ff   <= 1'b0;
            fs_len_ff <= '0;
            mf_len_ff <= '0;
            idle_ff   <= '0;
        end
        else
        begin
            ref_q_ff  <= ref_clk_in;
            fs_q_ff   <= frame_sync_out;
            mf_q_ff   <= multiframe_sync_out;
            // Sync pin activity may shorten a low phase
            warm_ff   <= (sync_pins == 3'h0) & (warm_ff | (fs_q_ff & ~frame_sync_out));
            fs_len_ff <= (frame_sync_out != fs_q_ff) ? 14'h0001 : fs_len_ff + 14'h0001;
            mf_len_ff <= (multiframe_sync_out != mf_q_ff) ? 14'h0001 : mf_len_ff + 14'h0001;
            if (ref_clk_in != ref_q_ff)
                idle_ff <= '0;
            else if (idle_ff != 16'hffff)
                idle_ff <= idle_ff + 16'h0001;
        end
    end

    ////////////////////////////////////////
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    sequence s_fs_fall;
        $fell(frame_sync_out);
    endsequence
    sequence s_refs_silent;
        idle_ff >= IDLE_LIM;
    endsequence

    chk_rdata_window: assert property (
        reg_rdata != 8'h00 |-> $past(reg_rd)) else $error("Read data outside its cycle");
    chk_bw_code_max: assert property (
        primary_bw <= 3'h5 && monitor_bw <= 3'h5) else $error("Bandwidth code above five");
    chk_fail_oe_write: assert property (
        $changed(selected_ref_fail_oe) |-> $past(ten_wr) || $past(ten_wr, 2))
        else $error("Fail pin enable moved without a write");
    chk_fs_high_len: assert property (
        s_fs_fall |-> fs_len_ff == 14'h061a) else $error("Frame sync high length wrong");
    chk_fs_low_len: assert property (
        $rose(frame_sync_out) && warm_ff |-> fs_len_ff == 14'h061b)
        else $error("Frame sync low length wrong");
    chk_mf_high_len: assert property (
        $fell(multiframe_sync_out) |-> mf_len_ff == MF_PERIOD / 2)
        else $error("Multiframe sync high length wrong");
    chk_mf_low_len: assert property (
        $rose(multiframe_sync_out) && warm_ff |-> mf_len_ff == MF_PERIOD - MF_PERIOD / 2)
        else $error("Multiframe sync low length wrong");
    chk_lock_needs_ref: assert property (
        $rose(lock_status) |-> idle_ff < IDLE_LIM) else $error("Lock without live reference");
    chk_silent_unlock: assert property (
        s_refs_silent |-> !lock_status) else $error("Lock kept with all inputs silent");
endmodule

bind rsd_ref_select rsd_ref_select_checker #(
    .ACT_TIMEOUT(ACT_TIMEOUT),
    .MF_PERIOD  (MF_PERIOD)
) i_rsd_ref_select_checker (
    .mclk                (mclk),
    .reset_n             (reset_n),
    .reg_addr            (reg_addr),
    .reg_wr              (reg_wr),
    .reg_rd              (reg_rd),
    .reg_rdata           (reg_rdata),
    .ref_clk_in          (ref_clk_in),
    .sync_pins           ({sync_input_three, sync_input_two, sync_input_one}),
    .frame_sync_out      (frame_sync_out),
    .multiframe_sync_out (multiframe_sync_out),
    .selected_ref_fail_oe(selected_ref_fail_oe),
    .lock_status         (lock_status),
    .primary_bw          (primary_bw),
    .monitor_bw          (monitor_bw)
);

/* sim/rsd_timing_cards.sv */
// Model of the timing cards that feed the reference inputs
`timescale 1ns/1ps
module rsd_timing_cards (
    input wire logic       mclk,
    input wire logic [4:0] run,
    output logic     [4:0] ref_clk
);
    // Each card toggles at its own rate; a stopped card holds its line
    for (genvar i = 0; i < 5; i++)
    begin : g_card
        int   cnt = 0;
        logic q   = 1'b0;
        assign ref_clk[i] = q;
        always_ff @(posedge mclk)
        begin
            if (run[i] && cnt >= i + 1)
            begin
                cnt <= 0;
                q   <= ~q;
            end
            else if (run[i])
                cnt <= cnt + 1;
        end
    end
endmodule

/* sim/tb_rsd_ref_select.sv */
// Testbench for the reference select and loop control block
`timescale 1ns/1ps
module tb_rsd_ref_select;
    import rsd_pkg::*;
    localparam int ACT = 50;
    logic       mclk;
    logic       reset_n;
    logic [5:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_rdata;
    logic [4:0] run;
    logic [4:0] ref_clk;
    logic       se_clk;
    logic       df_clk;
    logic       fail_o;
    logic       fail_oe;
    logic       lock_status;
    logic       fs_out;
    logic       sync_in;
    logic [2:0] p_bw;
    logic [2:0] m_bw;
    int         miscompares = 0;
    int         n_compared  = 0;
    int         cyc         = 0;

    rsd_ref_select #(.ACT_TIMEOUT(16'h0032), .MF_PERIOD(14'h0028)) i_rsd_ref_select (
        .mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ref_clk_in(ref_clk),
        .sync_input_one(1'b0), .sync_input_two(sync_in), .sync_input_three(1'b0),
        .single_ended_out_clock(se_clk), .differential_out_clock(df_clk),
        .frame_sync_out(fs_out), .multiframe_sync_out(), .selected_ref_fail_o(fail_o),
        .selected_ref_fail_oe(fail_oe), .lock_status(lock_status),
        .primary_bw(p_bw), .monitor_bw(m_bw));
    rsd_timing_cards i_rsd_timing_cards (.mclk(mclk), .run(run), .ref_clk(ref_clk));

    initial
    begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    ////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            miscompares++;
            $display("ERROR at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        wait_cyc(3);
    endtask
    task automatic rd_chk(input logic [5:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata & m, e);
    endtask
    // Output clock edges over a window: bit 1 differential, bit 0 single
    task automatic clk_chk(input logic [7:0] e);
        int ts;
        int td;
        logic s0;
        logic d0;
        ts = 0;
        td = 0;
        repeat (200)
        begin
            s0 = se_clk;
            d0 = df_clk;
            wait_cyc(1);
            if (se_clk !== s0) ts++;
            if (df_clk !== d0) td++;
        end
        chk({6'h00, td > 0, ts > 0}, e);
    endtask
    task automatic end_of_test();
        $display("Compared %0d, miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 15000)
        begin
            miscompares++;
            end_of_test();
        end
    end

    ////////////////////////////////////////
    initial
    begin
        reset_n   = 1'b0;
        reg_addr  = '0;
        reg_wdata = '0;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        sync_in   = 1'b0;
        run       = 5'h1f;
        repeat (10) @(posedge mclk);
        reset_n <= 1'b1;
        wait_cyc(3);
        rd_chk(RA_CTL_ONE, 8'hff, 8'h00);
        rd_chk(RA_PRI_P, 8'hff, 8'h01);
        rd_chk(RA_PRI_M + 6'h04, 8'hff, 8'h05);
        rd_chk(6'h0d, 8'hff, 8'h00);
        wait_cyc(100);
        rd_chk(RA_ACTIVITY, 8'h1f, 8'h1f);
        rd_chk(RA_SEL, 8'h07, 8'h00);
        wr(RA_PRI_P, 8'h00);
        rd_chk(RA_SEL, 8'h07, 8'h01);
        wr(RA_PRI_M + 6'h03, 8'h01);
        wr(RA_PRI_M, 8'h00);
        rd_chk(RA_SEL, 8'h77, 8'h31);
        // Lock, then lose every input and recover
        wait_cyc(2600);
        rd_chk(RA_STAT_TWO, 8'h0e, 8'h06);
        chk({7'h00, lock_status}, 8'h00);
        wr(RA_CTL_ONE, 8'h01);
        chk({7'h00, lock_status}, 8'h01);
        run = 5'h00;
        wait_cyc(ACT + 20);
        rd_chk(RA_STAT_TWO, 8'h0e, 8'h08);
        run = 5'h1f;
        wait_cyc(2700);
        rd_chk(RA_STAT_TWO, 8'h0e, 8'h06);
        wr(RA_CTL_ONE, 8'h0b);
        rd_chk(RA_STAT_TWO, 8'h0c, 8'h08);
        chk({7'h00, lock_status}, 8'h00);
        wr(RA_CTL_ONE, 8'h01);
        // Selected input dies; force onto it
        run = 5'h1d;
        wait_cyc(ACT + 20);
        rd_chk(RA_ACTIVITY, 8'h1f, 8'h1d);
        rd_chk(RA_SEL, 8'h07, 8'h02);
        wr(RA_FORCE_P, 8'h09);
        rd_chk(RA_SEL, 8'h07, 8'h01);
        rd_chk(RA_STAT_TWO, 8'h01, 8'h01);
        wr(RA_CTL_TEN, 8'h01);
        chk({6'h00, fail_oe, fail_o}, 8'h03);
        wr(RA_CTL_TEN, 8'h00);
        chk({7'h00, fail_oe}, 8'h00);
        // Only input 4 runs; primary forced to a silent input
        run = 5'h10;
        wr(RA_FORCE_P, 8'h08);
        wr(RA_FORCE_M, 8'h0c);
        rd_chk(RA_SEL, 8'h70, 8'h40);
        rd_chk(RA_MSTATE, 8'h01, 8'h01);
        // Input 4 against itself: one card period of twelve cycles
        wr(RA_PHASE_CTL, 8'h49);
        wait_cyc(40);
        rd_chk(RA_PHASE_LO, 8'hff, 8'h0c);
        rd_chk(RA_PHASE_HI, 8'hff, 8'h00);
        clk_chk(8'h00);
        wr(RA_CTL_TEN, 8'h02);
        clk_chk(8'h01);
        wr(RA_CTL_TEN, 8'h06);
        clk_chk(8'h02);
        // Sync edge in the low half pulls the next rise forward
        wr(RA_CTL_TEN, 8'h18);
        @(negedge fs_out);
        wait_cyc(20);
        @(posedge mclk);
        sync_in <= 1'b1;
        wait_cyc(3);
        chk({7'h00, fs_out}, 8'h00);
        wait_cyc(1);
        chk({7'h00, fs_out}, 8'h01);
        @(posedge mclk);
        sync_in <= 1'b0;
        wr(RA_BW, 8'h77);
        chk({1'b0, p_bw, 1'b0, m_bw}, 8'h55);
        wr(RA_BW, 8'h23);
        chk({1'b0, p_bw, 1'b0, m_bw}, 8'h32);
        end_of_test();
    end
endmodule
